// >>> rtl/sgp_gpio_port.sv
// Operation
// - Each pin has a software read-write direction bit, 0 input, 1 output.
// - Even bit selects route, odd bit direction; pins 0-15 low, 16-31 high register.
// - Input route 0 feeds input data register; route 1 feeds general interrupt path.
// - Output pins 0-15 route 1 drive the matching hot-plug port reset.
// - Output pins 16-31 route 1 is reserved; pin drives zero then.
// - Debounce word bit n filters pin n input when set.
// - Debounce only acts while the pin is an input.
// - Input data bit reads zero while pin is an output.
// - Route-0 input pin reads its current, optionally filtered, level; low bit n is pin n, high bit n is pin n+16.
// - Low readback register is read-only, upper half reads zero.
// - Direction and debounce registers live upstream only and reset to zero.
// - Output data reaches the pin only while the pin is an output.
// - High readback register gives zero for outputs and level for route-0 inputs.
`timescale 1ns/100ps
`default_nettype none
`include "sgp_defs.svh"
module sgp_gpio_port (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic                    isUpstreamPort,
    input  wire sgp_pkg::sgp_cfg_req_type cfgReq,
    output logic [31:0]                  cfgRdData,
    output logic                         cfgRdValid,
    input  wire logic [15:0]             hotPlugResetN,
    input  wire logic [31:0]             pinIn,
    output logic [31:0]                  pinOut,
    output logic [31:0]                  pinOutEn,
    output logic [31:0]                  pinIrqReq
);
    logic        rstSync1_q;
    logic        rstSync2_q;
    logic        rstLocal_n;
    logic [31:0] dirLow_q;
    logic [31:0] dirLow_d;
    logic [31:0] dirHigh_q;
    logic [31:0] dirHigh_d;
    logic [31:0] debounce_q;
    logic [31:0] debounce_d;
    logic [31:0] outData_q;
    logic [31:0] outData_d;
    logic [31:0] pinMeta_q;
    logic [31:0] pinSync_q;
    logic [31:0] filtLevel_q;
    logic [31:0] filtLevel_d;
    logic [7:0]  stableCnt_q [32];
    logic [7:0]  stableCnt_d [32];
    logic [31:0] inData_q;
    logic [31:0] inData_d;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic        rdValid_q;
    logic [31:0] pinOut_q;
    logic [31:0] pinOut_d;
    logic [31:0] pinOutEn_q;
    logic [31:0] pinOutEn_d;
    logic [31:0] irq_q;
    logic [31:0] irq_d;
    logic [31:0] isOut;
    logic [31:0] routeAlt;
    logic [31:0] effLevel;
    logic [31:0] wrMask;

    // Reset release is synchronised so every flop on rstLocal_n leaves reset on the same edge.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rstLocal_n = rstSync2_q;

    // Unpack the interleaved control pairs into per-pin vectors.
    always_comb begin
        sgp_pkg::sgp_pin_ctrl_type ctrl;
        ctrl = '0;
        for (int i = 0; i < 16; i++) begin
            ctrl = dirLow_q[2*i +: 2];
            isOut[i]    = ctrl.dirOut;
            routeAlt[i] = ctrl.routeAlt;
            ctrl = dirHigh_q[2*i +: 2];
            isOut[i+16]    = ctrl.dirOut;
            routeAlt[i+16] = ctrl.routeAlt;
        end
    end

    // Byte-lane write mask for the configuration write.
    assign wrMask = {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}}, {8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};

    // Register writes; the config registers exist only on the upstream port.
    always_comb begin
        dirLow_d   = dirLow_q;
        dirHigh_d  = dirHigh_q;
        debounce_d = debounce_q;
        outData_d  = outData_q;
        if (cfgReq.wrEn && isUpstreamPort) begin
            case (cfgReq.addr)
                `SGP_OFS_DIR_LOW:  dirLow_d   = (dirLow_q & ~wrMask) | (cfgReq.wrData & wrMask);
                `SGP_OFS_DIR_HIGH: dirHigh_d  = (dirHigh_q & ~wrMask) | (cfgReq.wrData & wrMask);
                `SGP_OFS_DEBOUNCE: debounce_d = (debounce_q & ~wrMask) | (cfgReq.wrData & wrMask);
                `SGP_OFS_OUT_LOW:  outData_d[15:0]  = (outData_q[15:0] & ~wrMask[15:0]) | (cfgReq.wrData[15:0] & wrMask[15:0]);
                `SGP_OFS_OUT_HIGH: outData_d[31:16] = (outData_q[31:16] & ~wrMask[15:0]) | (cfgReq.wrData[15:0] & wrMask[15:0]);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            dirLow_q   <= `SGP_RESET_WORD;
            dirHigh_q  <= `SGP_RESET_WORD;
            debounce_q <= `SGP_RESET_WORD;
            outData_q  <= `SGP_RESET_WORD;
        end else begin
            dirLow_q   <= dirLow_d;
            dirHigh_q  <= dirHigh_d;
            debounce_q <= debounce_d;
            outData_q  <= outData_d;
        end
    end

    // Two-stage synchroniser; only the second stage feeds the filters.
    always_ff @(posedge clk_sys or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            pinMeta_q <= `SGP_RESET_WORD;
            pinSync_q <= `SGP_RESET_WORD;
        end else begin
            pinMeta_q <= pinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // Stability filter: a level is accepted after holding for the sample count.
    // The counter restarts whenever the pin agrees with the filtered level, so a bouncing pin never moves.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            filtLevel_d[i] = filtLevel_q[i];
            stableCnt_d[i] = 8'h00;
            if (pinSync_q[i] != filtLevel_q[i]) begin
                if (stableCnt_q[i] == `SGP_STABLE_SAMPLES - 8'h01) begin
                    filtLevel_d[i] = pinSync_q[i];
                end else begin
                    stableCnt_d[i] = stableCnt_q[i] + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            filtLevel_q <= `SGP_RESET_WORD;
            for (int i = 0; i < 32; i++) begin
                stableCnt_q[i] <= 8'h00;
            end
        end else begin
            filtLevel_q <= filtLevel_d;
            stableCnt_q <= stableCnt_d;
        end
    end

    // Filtered level only applies to inputs; the filter is bypassed otherwise.
    assign effLevel = (debounce_q & ~isOut) & filtLevel_q | ~(debounce_q & ~isOut) & pinSync_q;

    // Input data capture, interrupt requests and pin drive.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (isOut[i]) begin
                inData_d[i] = 1'b0;
            end else if (routeAlt[i]) begin
                inData_d[i] = inData_q[i];
            end else begin
                inData_d[i] = effLevel[i];
            end
            irq_d[i]      = ~isOut[i] & routeAlt[i] & effLevel[i];
            pinOutEn_d[i] = isOut[i];
            if (!isOut[i]) begin
                pinOut_d[i] = 1'b0;
            end else if (!routeAlt[i]) begin
                pinOut_d[i] = outData_q[i];
            end else if (i < 16) begin
                pinOut_d[i] = hotPlugResetN[i % 16];
            end else begin
                pinOut_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            inData_q   <= `SGP_RESET_WORD;
            irq_q      <= `SGP_RESET_WORD;
            pinOut_q   <= `SGP_RESET_WORD;
            pinOutEn_q <= `SGP_RESET_WORD;
        end else begin
            inData_q   <= inData_d;
            irq_q      <= irq_d;
            pinOut_q   <= pinOut_d;
            pinOutEn_q <= pinOutEn_d;
        end
    end

    // Read mux; readback words are global, config words upstream only.
    // The last answer is held between reads so software always sees a steady word.
    always_comb begin
        rdData_d = rdData_q;
        if (cfgReq.rdEn) begin
            case (cfgReq.addr)
                `SGP_OFS_DIR_LOW:  rdData_d = isUpstreamPort ? dirLow_q : `SGP_RESET_WORD;
                `SGP_OFS_DIR_HIGH: rdData_d = isUpstreamPort ? dirHigh_q : `SGP_RESET_WORD;
                `SGP_OFS_DEBOUNCE: rdData_d = isUpstreamPort ? debounce_q : `SGP_RESET_WORD;
                `SGP_OFS_IN_LOW:   rdData_d = {`SGP_RESET_HALF, inData_q[15:0]};
                `SGP_OFS_IN_HIGH:  rdData_d = {`SGP_RESET_HALF, inData_q[31:16]};
                `SGP_OFS_OUT_LOW:  rdData_d = isUpstreamPort ? {`SGP_RESET_HALF, outData_q[15:0]} : `SGP_RESET_WORD;
                `SGP_OFS_OUT_HIGH: rdData_d = isUpstreamPort ? {`SGP_RESET_HALF, outData_q[31:16]} : `SGP_RESET_WORD;
                default:           rdData_d = `SGP_RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            rdData_q  <= `SGP_RESET_WORD;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= cfgReq.rdEn;
        end
    end

    assign cfgRdData  = rdData_q;
    assign cfgRdValid = rdValid_q;
    assign pinOut     = pinOut_q;
    assign pinOutEn   = pinOutEn_q;
    assign pinIrqReq  = irq_q;
endmodule
`default_nettype wire

// >>> rtl/sgp_defs.svh
`ifndef SGP_DEFS_SVH
`define SGP_DEFS_SVH
`define SGP_OFS_DIR_LOW      12'h62C
`define SGP_OFS_DIR_HIGH     12'h630
`define SGP_OFS_DEBOUNCE     12'h638
`define SGP_OFS_IN_LOW       12'h63C
`define SGP_OFS_IN_HIGH      12'h640
`define SGP_OFS_OUT_LOW      12'h644
`define SGP_OFS_OUT_HIGH     12'h648
`define SGP_RESET_WORD       32'h0000_0000
`define SGP_RESET_HALF       16'h0000
`define SGP_SEL_BIT          0
`define SGP_DIR_BIT          1
`define SGP_STABLE_SAMPLES   8'h10
`endif

// >>> rtl/sgp_pkg.sv
package sgp_pkg;
    // One pin's pair of control bits as held in a direction register.
    typedef struct packed {
        logic dirOut;
        logic routeAlt;
    } sgp_pin_ctrl_type;

    // Register access request from the configuration path.
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [11:0] addr;
        logic [31:0] wrData;
        logic [3:0]  byteEn;
    } sgp_cfg_req_type;
endpackage

// >>> test/sgp_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_board_model (
    input  wire logic [31:0] pinOut,
    input  wire logic [31:0] pinOutEn,
    input  wire logic [31:0] extLevel,
    output logic      [31:0] pinIn
);
    // A driven pin reads back its own drive, so a wrong enable shows up as a wrong level.
    assign pinIn = (pinOutEn & pinOut) | (~pinOutEn & extLevel);
endmodule
`default_nettype wire

// >>> test/sgp_gpio_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_gpio_port_properties (
    input wire logic                     clk_sys,
    input wire logic                     rst_n,
    input wire logic                     isUpstreamPort,
    input wire sgp_pkg::sgp_cfg_req_type cfgReq,
    input wire logic [31:0]              cfgRdData,
    input wire logic                     cfgRdValid,
    input wire logic [31:0]              pinOut,
    input wire logic [31:0]              pinOutEn,
    input wire logic [31:0]              pinIrqReq
);
    // Every check runs on the core clock and stays quiet while reset is low.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_idle_pin_low: assert property ((pinOut & ~pinOutEn) == 32'h0)
        else $error("pin driven while not an output");
    chk_dir_write_lands: assert property (cfgReq.wrEn && isUpstreamPort && cfgReq.addr == 12'h62C
        && cfgReq.byteEn == 4'hF |-> ##2 pinOutEn[0] == $past(cfgReq.wrData[1], 2))
        else $error("direction write not seen on enable");
    chk_read_answers: assert property (cfgReq.rdEn |=> cfgRdValid)
        else $error("read not answered next cycle");
    chk_answer_has_cause: assert property (cfgRdValid |-> $past(cfgReq.rdEn))
        else $error("read answer without request");
    chk_upper_half_zero: assert property (cfgRdValid && $past(cfgReq.addr) == 12'h63C |-> cfgRdData[31:16] == 16'h0)
        else $error("reserved readback bits not zero");
    chk_data_holds: assert property (!cfgRdValid |-> $stable(cfgRdData))
        else $error("read data moved without a read");
    chk_irq_inputs_only: assert property ((pinIrqReq & pinOutEn) == 32'h0)
        else $error("request raised by an output pin");
    chk_guest_read_blank: assert property (cfgReq.rdEn && !isUpstreamPort && cfgReq.addr == 12'h62C |=> cfgRdData == 32'h0)
        else $error("direction visible off the upstream port");
endmodule
`default_nettype wire

// >>> test/switch_gpio_port_config_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module switch_gpio_port_config_tb_top;
    logic                     clk_sys = 1'b0, rst_n = 1'b0, isUp = 1'b1, cfgRdValid;
    sgp_pkg::sgp_cfg_req_type cfgReq = '0;
    logic [15:0]              hp = 16'h0000;
    logic [31:0]              ext = 32'h0, cfgRdData, pinIn, pinOut, pinOutEn, pinIrqReq;
    int                       n_fail = 0, n_tests = 0;
    // Core clock of 10 MHz.
    always #50 clk_sys = ~clk_sys;
    sgp_gpio_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .isUpstreamPort(isUp), .cfgReq(cfgReq),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .hotPlugResetN(hp), .pinIn(pinIn),
        .pinOut(pinOut), .pinOutEn(pinOutEn), .pinIrqReq(pinIrqReq));
    sgp_board_model u_board (.pinOut(pinOut), .pinOutEn(pinOutEn), .extLevel(ext), .pinIn(pinIn));
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        n_fail += int'(seen !== expd);
        if (seen !== expd) $display("wrong value at %0t: %08h, expected %08h", $time, seen, expd);
    endtask
    // Inputs move 1 ns after an edge so they never race the design's flops.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // One access: a write, or a read whose one-cycle answer is judged right after the request edge.
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        cfgReq = '{w, !w, a, w ? d : 32'h0, 4'hF};
        tick(1);
        cfgReq = '0;
        if (!w) check(cfgRdValid === 1'b1 ? cfgRdData : ~d, d);
        tick(1);
    endtask
    task automatic t_regs();
        check(pinOutEn, 32'h0000_0000);
        acc(0, 12'h62C, 32'h0);
        acc(0, 12'h638, 32'h0);
        acc(1, 12'h630, 32'h5A5A_A5A5);
        acc(0, 12'h630, 32'h5A5A_A5A5);
        acc(0, 12'h100, 32'h0);
        isUp = 1'b0;
        acc(1, 12'h62C, 32'hFFFF_FFFF);
        acc(0, 12'h62C, 32'h0);
        isUp = 1'b1;
        acc(0, 12'h62C, 32'h0);
        $display("registers test done");
    endtask
    task automatic t_out();
        ext = 32'hFFFF_FFFF;
        hp = 16'hC3A5;
        acc(1, 12'h644, 32'h0000_5A5A);
        acc(1, 12'h62C, 32'hAAAA_AAAA);
        check(pinOut, 32'h0000_5A5A);
        acc(0, 12'h63C, 32'h0);
        // Upper output data is set so a reserved route that leaks it shows as ones.
        acc(1, 12'h648, 32'h0000_FFFF);
        acc(1, 12'h62C, 32'hFFFF_FFFF);
        acc(1, 12'h630, 32'hFFFF_FFFF);
        check(pinOut, 32'h0000_C3A5);
        check(pinOutEn, 32'hFFFF_FFFF);
        acc(1, 12'h630, 32'hAAAA_AAAA);
        check(pinOut, 32'hFFFF_C3A5);
        // The driven ones must reach the synchroniser before the readback means anything.
        tick(3);
        acc(0, 12'h640, 32'h0);
        acc(1, 12'h62C, 32'h0);
        $display("outputs test done");
    endtask
    task automatic t_in();
        acc(1, 12'h630, 32'h0);
        ext = 32'h1234_ABCD;
        tick(4);
        acc(0, 12'h63C, 32'h0000_ABCD);
        acc(0, 12'h640, 32'h0000_1234);
        acc(1, 12'h630, 32'h5555_5555);
        ext = 32'hEDCB_ABCD;
        tick(4);
        acc(0, 12'h640, 32'h0000_1234);
        check(pinIrqReq, 32'hEDCB_0000);
        $display("inputs test done");
    endtask
    // The filter must settle on the low level before the rise, hence the long first wait.
    task automatic t_debounce();
        ext = 32'h0;
        acc(1, 12'h638, 32'h0000_0001);
        tick(24);
        ext = 32'h0000_0003;
        tick(5);
        acc(0, 12'h63C, 32'h0000_0002);
        tick(20);
        acc(0, 12'h63C, 32'h0000_0003);
        $display("debounce test done");
    endtask
    // A mid-run reset must return every pin to an unfiltered input.
    task automatic t_reset();
        acc(1, 12'h62C, 32'hFFFF_FFFF);
        check(pinOutEn, 32'h0000_FFFF);
        rst_n = 1'b0;
        tick(2);
        check(pinOutEn, 32'h0000_0000);
        check(pinOut, 32'h0000_0000);
        rst_n = 1'b1;
        tick(3);
        acc(0, 12'h62C, 32'h0);
        acc(0, 12'h630, 32'h0);
        acc(0, 12'h638, 32'h0);
        $display("reset test done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hold reset for five cycles, then leave three edges for the internal release.
    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(3);
        t_regs();
        t_out();
        t_in();
        t_debounce();
        t_reset();
        tally_and_finish();
    end
endmodule
bind sgp_gpio_port sgp_gpio_port_properties u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .isUpstreamPort(isUpstreamPort),
    .cfgReq(cfgReq), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .pinOut(pinOut), .pinOutEn(pinOutEn),
    .pinIrqReq(pinIrqReq));
`default_nettype wire
